// *** psc_host_link.sv ***
// host serial controller and link receiver model facing the control block
`timescale 1ns/100ps
module psc_host_link (
    input  wire logic hclk,
    output logic      serial_chip_select_n,
    output logic      serial_read_active,
    output logic      serial_read_data,
    output logic      single_ended_sync_request_n
);
    initial begin
        serial_chip_select_n        = 1'b1;
        serial_read_active          = 1'b0;
        serial_read_data            = 1'b0;
        single_ended_sync_request_n = 1'b1;
    end

    // data line keeps changing so a stale bit can never look right
    always @(posedge hclk) begin
        serial_read_data <= ~serial_read_data;
    end

    // select low addresses the device; high means idle
    task automatic set_read(input logic cs_n, input logic act);
        @(posedge hclk);
        serial_chip_select_n <= cs_n;
        serial_read_active   <= act;
    endtask

    // low starts code group sync, the return to high starts lane alignment
    task automatic set_sync(input logic v);
        @(posedge hclk);
        single_ended_sync_request_n <= v;
    endtask
endmodule

// *** psc_pkg.sv ***
// constants and carrier types for the pin strap and clock-out control block
package psc_pkg;
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_OVR     = 8'h04;
    localparam logic [7:0] REG_STAT    = 8'h08;
    localparam logic [7:0] REG_IRQ_ST  = 8'h0C;
    localparam logic [7:0] REG_IRQ_MSK = 8'h10;

    localparam int CTRL_CLKOUT_DIS = 0;
    localparam int CTRL_D_OVR_EN   = 1;
    localparam int CTRL_D_DIV4     = 2;
    localparam int CTRL_SYNC_SEL   = 3;
    localparam int CTRL_MODE_8B10B = 4;
    localparam int CTRL_SYSREF_EN  = 5;
    localparam int CTRL_TIMESTAMP_INPUT_EN   = 6;
    localparam int CTRL_TS_USE     = 7;
    localparam int CTRL_W          = 8;
    localparam logic [7:0] CTRL_RESET = 8'h30;

    localparam int OVR_THR_LSB  = 0;
    localparam int OVR_HOLD_LSB = 16;
    localparam logic [11:0] OVR_THR_RESET  = 12'h800;
    localparam logic [3:0]  OVR_HOLD_RESET = 4'h4;

    localparam int IRQ_OVR_D = 0;
    localparam int IRQ_OVR_C = 1;
    localparam int IRQ_CGS   = 2;
    localparam int IRQ_ILAS  = 3;
    localparam int IRQ_STRAP = 4;
    localparam int IRQ_W     = 5;

    localparam logic [1:0] CFG_OFF  = 2'h0;
    localparam logic [1:0] CFG_COPY = 2'h1;
    localparam logic [1:0] CFG_DIV2 = 2'h2;
    localparam logic [1:0] CFG_DIV4 = 2'h3;

    // pin sampler order: straps, sync, chip select, two reference clocks
    localparam int PIN_W = 9;
    localparam logic [8:0] PIN_RESET = 9'h00C;

    typedef struct packed {
        logic       pd;
        logic       pll_en;
        logic       ref_se;
        logic [1:0] cfg;
    } psc_strap_t;
endpackage

// *** psc_top.sv ***
// pin strap, clock-out mux, sync request and receiver-enable control with AHB-Lite registers
//
// Behaviour
// - channel-D over-range pin rises above threshold
// - over-range pulse held at least hold length
// - straps low or disabled: pin shows over-range
// - any strap set, PLL enabled and powered up: pin carries reference copy or its divide by two or four
// - override selects D divide by two or four
// - D clock only while C clock runs
// - power-down stops reference and pin clocks
// - PLL enable pin enables, low bypasses PLL
// - reference select; PLL off forces differential
// - reference output repeats selected reference input only while PLL enabled and not powered down
// - serial data out driven only during reads
// - sync input used only 8b10b, select zero
// - sync low starts CGS, high starts ILAS
// - SYSREF receiver powered by its enable
// - timestamp receiver off when unused and disabled
// - C pin codes: copy, divide two, four
`timescale 1ns/100ps
module psc_top #(
    parameter int SAMPLE_W = 12,
    parameter int HOLD_W   = 4
) (
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic [31:0]              hrdata,
    input  wire logic [SAMPLE_W-1:0] sample_mag_c,
    input  wire logic [SAMPLE_W-1:0] sample_mag_d,
    input  wire logic                power_down_input,
    input  wire logic                pll_enable_strap,
    input  wire logic                refclk_source_select,
    input  wire logic [1:0]          clock_out_config_strap,
    input  wire logic                diff_refclk,
    input  wire logic                single_ended_refclk,
    input  wire logic                single_ended_sync_request_n,
    input  wire logic                serial_chip_select_n,
    input  wire logic                serial_read_active,
    input  wire logic                serial_read_data,
    output logic                     overrange_c_pin,
    output logic                     overrange_d_pin,
    output logic                     refclk_repeat_output,
    output logic                     pll_enable_out,
    output logic                     sampling_clk_single_ended,
    output logic                     sdo_out,
    output logic                     sdo_oe,
    output logic                     cgs_request,
    output logic                     ilas_start,
    output logic                     sysref_rx_power_on,
    output logic                     timestamp_rx_power_on,
    output logic                     irq
);
    initial begin
        if (SAMPLE_W < 1 || SAMPLE_W > 16 || HOLD_W < 1 || HOLD_W > 8) begin
            $error("psc_top: SAMPLE_W must be 1..16 and HOLD_W 1..8");
        end
    end

    localparam int HW = HOLD_W;

    function automatic logic [31:0] zext(input logic [15:0] v);
        zext = {16'h0000, v};
    endfunction

    // ---------------- pin sampling ----------------
    logic [psc_pkg::PIN_W-1:0] pin_meta;
    logic [psc_pkg::PIN_W-1:0] pin_sync;
    logic [psc_pkg::PIN_W-1:0] pin_raw;
    psc_pkg::psc_strap_t        strap;
    psc_pkg::psc_strap_t        strap_prev;
    logic                       sync_n_s;
    logic                       cs_n_s;
    logic                       ref_diff_s;
    logic                       ref_se_s;

    assign pin_raw = {power_down_input, pll_enable_strap, refclk_source_select,
                      clock_out_config_strap, single_ended_sync_request_n,
                      serial_chip_select_n, diff_refclk, single_ended_refclk};

    // chip select and sync request reset high so an undriven pin reads idle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_meta <= psc_pkg::PIN_RESET;
            pin_sync <= psc_pkg::PIN_RESET;
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
        end
    end

    assign strap      = pin_sync[8:4];
    assign sync_n_s   = pin_sync[3];
    assign cs_n_s     = pin_sync[2];
    assign ref_diff_s = pin_sync[1];
    assign ref_se_s   = pin_sync[0];

    // ---------------- registers ----------------
    logic [psc_pkg::CTRL_W-1:0] ctrl;
    logic [SAMPLE_W-1:0]        ovr_thr;
    logic [HW-1:0]              ovr_hold;
    logic [psc_pkg::IRQ_W-1:0]  irq_st;
    logic [psc_pkg::IRQ_W-1:0]  irq_msk;
    logic [psc_pkg::IRQ_W-1:0]  irq_ev;
    logic [psc_pkg::IRQ_W-1:0]  irq_clr;
    logic [psc_pkg::IRQ_W-1:0]  next_irq_st;
    logic [psc_pkg::IRQ_W-1:0]  next_irq_msk;
    logic                       wr_pend;
    logic [7:0]                 wr_addr;
    logic                       addr_ok;
    logic [31:0]                rd_word;
    logic [15:0]                stat_word;

    assign addr_ok = hsel && htrans[1] && hready;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else if (hready) begin
            wr_pend <= addr_ok && hwrite;
            wr_addr <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl     <= psc_pkg::CTRL_RESET;
            ovr_thr  <= SAMPLE_W'(psc_pkg::OVR_THR_RESET);
            ovr_hold <= HW'(psc_pkg::OVR_HOLD_RESET);
            irq_msk  <= '0;
        end else if (wr_pend) begin
            unique case (wr_addr)
                psc_pkg::REG_CTRL: ctrl <= hwdata[psc_pkg::CTRL_W-1:0];
                psc_pkg::REG_OVR: begin
                    ovr_thr  <= hwdata[psc_pkg::OVR_THR_LSB +: SAMPLE_W];
                    ovr_hold <= hwdata[psc_pkg::OVR_HOLD_LSB +: HW];
                end
                psc_pkg::REG_IRQ_MSK: irq_msk <= hwdata[psc_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    assign irq_clr = (wr_pend && wr_addr == psc_pkg::REG_IRQ_ST)
                   ? hwdata[psc_pkg::IRQ_W-1:0] : '0;
    // a new event in the clearing cycle survives the clear
    assign next_irq_st = (irq_st & ~irq_clr) | irq_ev;
    // the level must follow a mask written in the same cycle, not lag it by one
    assign next_irq_msk = (wr_pend && wr_addr == psc_pkg::REG_IRQ_MSK)
                        ? hwdata[psc_pkg::IRQ_W-1:0] : irq_msk;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_st <= '0;
            irq    <= 1'b0;
        end else begin
            irq_st <= next_irq_st;
            irq    <= |(next_irq_st & next_irq_msk);
        end
    end

    // read data is fetched in the address phase; zero wait states
    always_comb begin
        unique case (haddr[7:0])
            psc_pkg::REG_CTRL:    rd_word = zext(16'(ctrl));
            psc_pkg::REG_OVR:     rd_word = (32'(ovr_hold) << psc_pkg::OVR_HOLD_LSB)
                                          | 32'(ovr_thr);
            psc_pkg::REG_STAT:    rd_word = zext(stat_word);
            psc_pkg::REG_IRQ_ST:  rd_word = zext(16'(irq_st));
            psc_pkg::REG_IRQ_MSK: rd_word = zext(16'(irq_msk));
            default:              rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (addr_ok && !hwrite) begin
                hrdata <= rd_word;
            end
        end
    end

    // ---------------- over-range detect and stretch ----------------
    logic [SAMPLE_W-1:0] mag     [2];
    logic [HW-1:0]       hold_cnt[2];
    logic [1:0]          ov_hit;
    logic [1:0]          ov_q;

    assign mag[0] = sample_mag_c;
    assign mag[1] = sample_mag_d;

    for (genvar i = 0; i < 2; i++) begin : g_ovr
        assign ov_hit[i] = mag[i] > ovr_thr;
    end

    // one process for both channels keeps every variable single-driven
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_cnt <= '{default: '0};
            ov_q     <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (ov_hit[i]) begin
                    hold_cnt[i] <= ovr_hold;
                end else if (hold_cnt[i] != '0) begin
                    hold_cnt[i] <= hold_cnt[i] - HW'(1);
                end
                ov_q[i] <= ov_hit[i] || (hold_cnt[i] > HW'(1));
            end
        end
    end

    // ---------------- reference clock copies ----------------
    // reference is sampled on hclk, so it must stay below a quarter of hclk
    logic       clk_allow;
    logic       ref_sel;
    logic       ref_prev;
    logic [1:0] div_cnt;
    logic [1:0] c_code;
    logic       c_src;
    logic       d_src;
    logic       c_clk_on;
    logic       d_clk_on;

    assign clk_allow = strap.pll_en && !strap.pd;
    // the single-ended reference only serves through the PLL
    assign ref_sel = (strap.pll_en && strap.ref_se) ? ref_se_s : ref_diff_s;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_prev <= 1'b0;
            div_cnt  <= 2'h0;
        end else begin
            ref_prev <= ref_sel;
            if (ref_sel && !ref_prev) begin
                div_cnt <= div_cnt + 2'h1;
            end
        end
    end

    assign c_code = ctrl[psc_pkg::CTRL_CLKOUT_DIS] ? psc_pkg::CFG_OFF : strap.cfg;

    always_comb begin
        unique case (c_code)
            psc_pkg::CFG_COPY: c_src = ref_sel;
            psc_pkg::CFG_DIV2: c_src = div_cnt[0];
            psc_pkg::CFG_DIV4: c_src = div_cnt[1];
            psc_pkg::CFG_OFF:  c_src = 1'b0;
        endcase
    end

    assign c_clk_on = (c_code != psc_pkg::CFG_OFF) && clk_allow;
    assign d_clk_on = c_clk_on;
    assign d_src = !ctrl[psc_pkg::CTRL_D_OVR_EN] ? ref_sel
                 : (ctrl[psc_pkg::CTRL_D_DIV4] ? div_cnt[1] : div_cnt[0]);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            overrange_c_pin           <= 1'b0;
            overrange_d_pin           <= 1'b0;
            refclk_repeat_output      <= 1'b0;
            pll_enable_out            <= 1'b0;
            sampling_clk_single_ended <= 1'b0;
        end else begin
            overrange_c_pin           <= c_clk_on ? c_src : ov_q[0];
            overrange_d_pin           <= d_clk_on ? d_src : ov_q[1];
            refclk_repeat_output      <= clk_allow && ref_sel;
            pll_enable_out            <= clk_allow;
            sampling_clk_single_ended <= strap.pll_en && strap.ref_se;
        end
    end

    // ---------------- serial data out and link sync ----------------
    logic link_sync_used;
    logic sync_prev_n;

    assign link_sync_used = ctrl[psc_pkg::CTRL_MODE_8B10B]
                         && !ctrl[psc_pkg::CTRL_SYNC_SEL];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sdo_oe                <= 1'b0;
            sdo_out               <= 1'b0;
            sync_prev_n           <= 1'b1;
            cgs_request           <= 1'b0;
            ilas_start            <= 1'b0;
            sysref_rx_power_on    <= 1'b0;
            timestamp_rx_power_on <= 1'b0;
            strap_prev            <= '0;
        end else begin
            // serial clocking comes from the host; only the drive window is ours
            sdo_oe      <= serial_read_active && !cs_n_s;
            sdo_out     <= serial_read_active && !cs_n_s && serial_read_data;
            sync_prev_n <= sync_n_s;
            cgs_request <= link_sync_used && !sync_n_s;
            ilas_start  <= link_sync_used && !sync_prev_n && sync_n_s;
            sysref_rx_power_on    <= ctrl[psc_pkg::CTRL_SYSREF_EN];
            timestamp_rx_power_on <= ctrl[psc_pkg::CTRL_TIMESTAMP_INPUT_EN]
                                  || ctrl[psc_pkg::CTRL_TS_USE];
            strap_prev  <= strap;
        end
    end

    assign irq_ev[psc_pkg::IRQ_OVR_D] = ov_hit[1];
    assign irq_ev[psc_pkg::IRQ_OVR_C] = ov_hit[0];
    assign irq_ev[psc_pkg::IRQ_CGS]   = link_sync_used && sync_prev_n && !sync_n_s;
    assign irq_ev[psc_pkg::IRQ_ILAS]  = link_sync_used && !sync_prev_n && sync_n_s;
    assign irq_ev[psc_pkg::IRQ_STRAP] = strap != strap_prev;

    assign stat_word = {5'h00, sync_n_s, ov_q[1], ov_q[0], d_clk_on,
                        c_clk_on, clk_allow, strap};

    // ---------------- checks ----------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    ovr_d_rise_a: assert property (ov_hit[1] ##1 !d_clk_on |=> overrange_d_pin)
        else $error("D over-range pin did not rise");
    ovr_min_hold_a: assert property (ov_hit[1] && ovr_hold >= HW'(3) ##1 !d_clk_on[*3]
            |=> overrange_d_pin && $past(overrange_d_pin) && $past(overrange_d_pin, 2))
        else $error("D over-range pulse too short");
    pin_ovr_mode_a: assert property (!c_clk_on |=> overrange_d_pin == $past(ov_q[1]))
        else $error("D pin not carrying over-range");
    d_needs_c_a: assert property (d_clk_on |-> clk_allow && strap.cfg != psc_pkg::CFG_OFF
            && !ctrl[psc_pkg::CTRL_CLKOUT_DIS])
        else $error("D clock without C clock");
    pd_gates_a: assert property (strap.pd |=> !refclk_repeat_output && !pll_enable_out)
        else $error("power-down left reference output on");
    pll_off_a: assert property (!strap.pll_en |=> !sampling_clk_single_ended
            && !pll_enable_out)
        else $error("PLL or single-ended select with PLL off");
    sdo_quiet_a: assert property (!serial_read_active |=> !sdo_oe)
        else $error("serial output driven outside a read");
    sync_ignored_a: assert property (!link_sync_used |=> !cgs_request && !ilas_start)
        else $error("sync request used in wrong mode");
    ilas_after_cgs_a: assert property ($rose(ilas_start) |-> $past(cgs_request))
        else $error("lane alignment without prior CGS");
    timestamp_input_off_a: assert property (!ctrl[psc_pkg::CTRL_TIMESTAMP_INPUT_EN]
            && !ctrl[psc_pkg::CTRL_TS_USE] |=> !timestamp_rx_power_on)
        else $error("timestamp receiver left powered");
    irq_level_a: assert property (|(irq_st & irq_msk) |-> irq)
        else $error("interrupt low with unmasked status");
    ref_repeat_a: assert property (clk_allow |=> refclk_repeat_output == $past(ref_sel))
        else $error("reference output does not repeat the input");
    c_copy_a: assert property (c_clk_on && c_code == psc_pkg::CFG_COPY
            |=> overrange_c_pin == $past(ref_sel))
        else $error("C pin not carrying the reference copy");
    sdo_data_a: assert property (serial_read_active && !cs_n_s
            |=> sdo_oe && sdo_out == $past(serial_read_data))
        else $error("serial output wrong during a read");
    cgs_level_a: assert property (link_sync_used && !sync_n_s |=> cgs_request)
        else $error("CGS request not raised");
    // gated by the sampled reset so the release edge itself is not judged
    sysref_pwr_a: assert property (hresetn |=> sysref_rx_power_on
            == $past(ctrl[psc_pkg::CTRL_SYSREF_EN]))
        else $error("SYSREF receiver power not following its enable");
endmodule

// *** test_pin_strap_clockout_control.sv ***
// self-checking bench for the pin strap and clock-out control block
`timescale 1ns/100ps
module test_pin_strap_clockout_control;
    logic                hclk = 1'b0;
    logic                hresetn = 1'b0;
    logic                hsel = 1'b0;
    logic [31:0]         haddr = 32'h0;
    logic [1:0]          htrans = 2'h0;
    logic                hwrite = 1'b0;
    logic [2:0]          hsize = 3'h2;
    logic [31:0]         hwdata = 32'h0;
    logic                hreadyout, hresp;
    logic [31:0]         hrdata;
    logic [11:0]         mag_c = 12'h0;
    logic [11:0]         mag_d = 12'h0;
    psc_pkg::psc_strap_t st = '0;
    logic                ref_d = 1'b0;
    logic                ref_s = 1'b0;
    logic                cs_n, rd_act, rd_dat, sync_n;
    logic                or_c, or_d, ref_o, pll_o, smp_se, sdo, sdo_oe;
    logic                cgs, ilas, sys_on, ts_on, irq;
    int                  mismatches = 0;
    int                  check_count = 0;
    int                  cyc = 0;
    logic [31:0]         q, n;
    logic [7:0]          sctl [3] = '{8'h30, 8'h38, 8'h20};

    always #20 hclk = ~hclk;

    // two unrelated reference periods: 16 and 24 bus clocks
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc % 8 == 7) ref_d <= ~ref_d;
        if (cyc % 12 == 11) ref_s <= ~ref_s;
    end

    psc_top u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .sample_mag_c(mag_c), .sample_mag_d(mag_d), .power_down_input(st.pd),
        .pll_enable_strap(st.pll_en), .refclk_source_select(st.ref_se),
        .clock_out_config_strap(st.cfg), .diff_refclk(ref_d), .single_ended_refclk(ref_s),
        .single_ended_sync_request_n(sync_n), .serial_chip_select_n(cs_n),
        .serial_read_active(rd_act), .serial_read_data(rd_dat),
        .overrange_c_pin(or_c), .overrange_d_pin(or_d), .refclk_repeat_output(ref_o),
        .pll_enable_out(pll_o), .sampling_clk_single_ended(smp_se), .sdo_out(sdo),
        .sdo_oe(sdo_oe), .cgs_request(cgs), .ilas_start(ilas), .sysref_rx_power_on(sys_on),
        .timestamp_rx_power_on(ts_on), .irq(irq)
    );

    psc_host_link u_far (
        .hclk(hclk), .serial_chip_select_n(cs_n), .serial_read_active(rd_act),
        .serial_read_data(rd_dat), .single_ended_sync_request_n(sync_n)
    );

    task automatic results;
        if (mismatches == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk1(input string nm, input logic e, input logic g);
        check(nm, {31'h0, e}, {31'h0, g});
    endtask

    task automatic wait_rdy;
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 64);
        if (hreadyout !== 1'b1) begin
            mismatches++;
            results();
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        xfer(1'b0, a, 32'h0);
    endtask

    function automatic logic pick(input int s);
        return s == 0 ? or_c : (s == 1 ? or_d : ref_o);
    endfunction

    // cycles between two rising edges; 0 when the pin does not toggle
    task automatic period(input int s, output logic [31:0] p);
        logic prev;
        int   t0;
        prev = pick(s);
        t0 = -1;
        p = 32'h0;
        for (int k = 0; k < 200 && p == 0; k++) begin
            @(posedge hclk);
            if (pick(s) && !prev) begin
                if (t0 >= 0) p = 32'(k - t0);
                else t0 = k;
            end
            prev = pick(s);
        end
    endtask

    // straps as {pd, pll_en, ref_se, cfg}; an all-ones reference period skips that pin
    task automatic clk_case(input logic [4:0] s, input logic [7:0] c,
                            input logic [31:0] ec, input logic [31:0] ed, input logic [31:0] er);
        wr(psc_pkg::REG_CTRL, {24'h0, c});
        st <= psc_pkg::psc_strap_t'(s);
        repeat (80) @(posedge hclk);
        period(0, q);
        check("c_period", ec, q);
        period(1, q);
        check("d_period", ed, q);
        period(2, q);
        if (er != '1) check("ref_period", er, q);
        chk1("pll_out", s[3] & ~s[4], pll_o);
        chk1("se_feed", s[2] & s[3], smp_se);
        rd(psc_pkg::REG_STAT);
        check("stat_straps", {27'h0, s}, {27'h0, q[4:0]});
    endtask

    task automatic ovr_hit(input logic [11:0] m, output logic [31:0] cnt);
        mag_d <= m;
        @(posedge hclk);
        mag_d <= 12'h0;
        cnt = 0;
        repeat (12) begin
            @(posedge hclk);
            if (or_d === 1'b1) cnt++;
        end
    endtask

    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        rd(psc_pkg::REG_CTRL);
        check("ctrl_rst", 32'h30, q);
        chk1("hresp_okay", 1'b0, hresp);
        rd(psc_pkg::REG_OVR);
        check("ovr_rst", 32'h0004_0800, q);
        rd(psc_pkg::REG_IRQ_MSK);
        check("msk_rst", 32'h0, q);
        rd(8'h14);
        check("unmapped", 32'h0, q);
        chk1("sysref_on", 1'b1, sys_on);
        chk1("ts_off", 1'b0, ts_on);
        wr(psc_pkg::REG_CTRL, 32'h70);
        repeat (3) @(posedge hclk);
        chk1("ts_en", 1'b1, ts_on);
        wr(psc_pkg::REG_CTRL, 32'h90);
        repeat (3) @(posedge hclk);
        chk1("ts_used", 1'b1, ts_on);
        chk1("sysref_off", 1'b0, sys_on);
        wr(psc_pkg::REG_CTRL, 32'h30);
        repeat (3) @(posedge hclk);
        chk1("ts_unused", 1'b0, ts_on);
        // over-range on the D pin, with interrupt raise, mask and clear
        wr(psc_pkg::REG_OVR, 32'h0003_0100);
        wr(psc_pkg::REG_IRQ_MSK, 32'h1);
        ovr_hit(12'h100, n);
        check("ovr_equal", 32'h0, n);
        ovr_hit(12'h101, n);
        check("ovr_len", 32'd3, n);
        chk1("irq_set", 1'b1, irq);
        mag_c <= 12'hFFF;
        @(posedge hclk);
        mag_c <= 12'h0;
        repeat (3) @(posedge hclk);
        rd(psc_pkg::REG_IRQ_ST);
        check("irq_st", 32'h3, q & 32'h3);
        wr(psc_pkg::REG_IRQ_ST, 32'h1);
        repeat (3) @(posedge hclk);
        chk1("irq_masked", 1'b0, irq);
        rd(psc_pkg::REG_IRQ_ST);
        check("irq_w1c", 32'h2, q & 32'h3);
        wr(psc_pkg::REG_IRQ_ST, 32'h1F);
        // clock-out modes, strap changes applied without reset
        clk_case(5'b01001, 8'h30, 32'd16, 32'd16, 32'd16);
        clk_case(5'b01010, 8'h30, 32'd32, 32'd16, 32'd16);
        clk_case(5'b01011, 8'h30, 32'd64, 32'd16, 32'd16);
        clk_case(5'b01001, 8'h32, 32'd16, 32'd32, 32'd16);
        clk_case(5'b01001, 8'h36, 32'd16, 32'd64, 32'd16);
        clk_case(5'b01101, 8'h30, 32'd24, 32'd24, 32'd24);
        clk_case(5'b00101, 8'h30, 32'd0, 32'd0, 32'd0);
        clk_case(5'b11001, 8'h30, 32'd0, 32'd0, 32'd0);
        clk_case(5'b01000, 8'h32, 32'd0, 32'd0, 32'd16);
        clk_case(5'b01001, 8'h31, 32'd0, 32'd0, 32'd16);
        ovr_hit(12'hFFF, n);
        check("ovr_shown", 32'd3, n);
        // sync request used only in 8b/10b with select zero
        for (int i = 0; i < 3; i++) begin
            wr(psc_pkg::REG_CTRL, {24'h0, sctl[i]});
            u_far.set_sync(1'b0);
            repeat (6) @(posedge hclk);
            chk1("cgs", i == 0, cgs);
            u_far.set_sync(1'b1);
            n = 0;
            repeat (8) begin
                @(posedge hclk);
                if (ilas === 1'b1) n++;
            end
            check("ilas", 32'(i == 0), n);
            chk1("cgs_end", 1'b0, cgs);
            rd(psc_pkg::REG_IRQ_ST);
            check("irq_sync", (i == 0) ? 32'hC : 32'h0, q & 32'hC);
            wr(psc_pkg::REG_IRQ_ST, 32'h1F);
        end
        // serial data output driven only during a selected read
        u_far.set_read(1'b0, 1'b1);
        repeat (5) @(posedge hclk);
        chk1("sdo_rd", 1'b1, sdo_oe);
        chk1("sdo_data", ~rd_dat, sdo);
        u_far.set_read(1'b0, 1'b0);
        repeat (5) @(posedge hclk);
        chk1("sdo_idle", 1'b0, sdo_oe);
        chk1("sdo_low", 1'b0, sdo);
        u_far.set_read(1'b1, 1'b1);
        repeat (5) @(posedge hclk);
        chk1("sdo_unsel", 1'b0, sdo_oe);
        u_far.set_read(1'b1, 1'b0);
        results();
    end
endmodule
